// File: pkg/arsq_pkg.sv
// Constants, register map and types of the auto-reclose sequencer.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
//
// Behaviour
// - Breaker position input high means breaker open, low means closed.
// - Close only while synchronism input is high and close-block input is low.
// - Three internal initiation lines and one external initiation line.
// - Each shot and line has start, block or no-action setting.
// - Action codes: 0 none, 1 start, 2 block; yes/no options are 1/0.
// - Never start a shot numbered below the current shot pointer.
// - Start only when a start line is active and no block line is.
// - A blocked shot falls through to the lowest later startable shot or final trip.
// - Blocking never advances the pointer; otherwise wait for release or definite trip.
// - Trip-initiated shots start at once; protection opens the breaker itself.
// - Start-signal shots open the breaker after their start delay; zero allowed.
// - A separate start delay for every shot and line pair.
// - Start delay runs only while its line stays active; blocking lines ignored.
// - Delay elapsed under an active block starts the shot 50 ms after release.
// - Dead time runs from breaker trip; then close and start reclaim, discrimination.
// - Initiation during discrimination after shots one to four sets pointer to 6.
// - Discrimination time of zero disables that function.
// - Every close restarts reclaim; initiation during reclaim runs the next shot.
// - After all shots pointer goes to 7; reclaim expiry returns it to 1.
// - At lock-out every initiation line is ignored until reclaim runs out.
// - Open and close commands are never active together; open wins.
package arsq_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = (TICK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_TIME_MS = 50;
    localparam int TW = 16;
    localparam logic [TW-1:0] GAP_MS = TW'(GAP_TIME_MS / TICK_MS);
    localparam int NUM_SHOTS = 5;
    localparam int NUM_LINES = 4;
    localparam int AW = 8;

    localparam logic [AW-1:0] OFF_CTRL = 8'h00;
    localparam logic [AW-1:0] OFF_STATUS = 8'h04;
    localparam logic [AW-1:0] OFF_TD = 8'h08;
    localparam logic [AW-1:0] OFF_TR = 8'h0C;
    localparam logic [AW-1:0] OFF_ACT = 8'h10;
    localparam logic [AW-1:0] OFF_DEAD = 8'h28;
    localparam logic [AW-1:0] OFF_DLY = 8'h40;
    localparam int IDX_CTRL = int'(OFF_CTRL) / 4;
    localparam int IDX_STATUS = int'(OFF_STATUS) / 4;
    localparam int IDX_TD = int'(OFF_TD) / 4;
    localparam int IDX_TR = int'(OFF_TR) / 4;
    localparam int IDX_ACT = int'(OFF_ACT) / 4;
    localparam int IDX_DEAD = int'(OFF_DEAD) / 4;
    localparam int IDX_DLY = int'(OFF_DLY) / 4;

    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_START = 2'h1;
    localparam logic [1:0] ACT_BLOCK = 2'h2;
    localparam logic [2:0] PTR_FIRST = 3'h1;
    localparam logic [2:0] PTR_LAST = 3'h5;
    localparam logic [2:0] PTR_FINAL = 3'h6;
    localparam logic [2:0] PTR_LOCK = 3'h7;
    localparam logic [2:0] PTR_NONE = 3'h0;

    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic [TW-1:0] TD_RST = 16'h0000;
    localparam logic [TW-1:0] TR_RST = 16'h2710;
    localparam logic [TW-1:0] DEAD_RST = 16'h01F4;

    typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_OPEN, ST_DEAD, ST_CLOSE} arsq_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [AW-1:0] paddr;
        logic [31:0] pwdata;
    } arsq_apb_s;

    typedef struct packed {
        logic reclose_inhibit_in;
        logic close_block_in;
        logic sync_ok_in;
        logic breaker_open_sense;
        logic init_line_external;
        logic init_line_three;
        logic init_line_two;
        logic init_line_one;
    } arsq_pins_s;

    typedef struct packed {
        arsq_pins_s s1;
        arsq_pins_s s2;
        arsq_state_e st;
        logic [2:0] ptr;
        logic [2:0] shot;
        logic open_cmd;
        logic close_cmd;
        logic held;
        logic [NUM_LINES-1:0][TW-1:0] lcnt;
        logic [TW-1:0] dead_cnt;
        logic [TW-1:0] disc;
        logic [TW-1:0] recl;
        logic [TW-1:0] gap;
        logic [4:0] mode;
        logic [TW-1:0] td;
        logic [TW-1:0] tr;
        logic [NUM_SHOTS:0][7:0] act;
        logic [NUM_SHOTS-1:0][TW-1:0] dead;
        logic [(NUM_SHOTS+1)*NUM_LINES-1:0][TW-1:0] dly;
        logic [31:0] prdata;
    } arsq_regs_s;
endpackage

// File: rtl/arsq_tick.sv
// Millisecond tick divider of the auto-reclose sequencer.
// Assumes one pclk domain; the tick is a one-cycle enable.
`timescale 1ns/1ps
`default_nettype none
module arsq_tick #(
    parameter int CYCLES = 10000
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    localparam int CW = $clog2(CYCLES);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tick;
    } arsq_tick_s;

    arsq_tick_s r_reg;
    arsq_tick_s r_next;

    if (CYCLES < 2) begin : g_bad
        $error("arsq_tick: CYCLES must be at least 2");
    end

    always_comb begin
        r_next = r_reg;
        r_next.tick = 1'b0;
        if (r_reg.cnt == CW'(CYCLES - 1)) begin
            r_next.cnt = '0;
            r_next.tick = 1'b1;
        end else begin
            r_next.cnt = r_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign tick = r_reg.tick;

    property p_tick_single;
        @(posedge pclk) disable iff (!presetn) tick |=> !tick;
    endproperty
    a_tick_single: assert property (p_tick_single) else $error("tick lasted two cycles");
endmodule
`default_nettype wire

// File: rtl/arsq_top.sv
// Auto-reclose sequencer: shot pointer, start delays, dead time, reclaim.
// Assumes pins arrive asynchronously and an APB master on pclk.
`timescale 1ns/1ps
`default_nettype none
module arsq_top
    import arsq_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire arsq_apb_s apb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire arsq_pins_s pins,
    output logic breaker_open_cmd,
    output logic breaker_close_cmd,
    output logic [2:0] shot_pointer,
    output logic [NUM_SHOTS-1:0] shot_pending
);
    arsq_regs_s r_reg;
    arsq_regs_s r_next;
    logic tick;
    logic [2:0] sel;
    logic go;
    logic hold_now;
    logic [NUM_LINES-1:0] lines;
    logic brk;
    logic syn;
    logic cblk;
    logic inh;
    logic [5:0] idx;
    logic mapped;
    logic [31:0] rd;

    if (TICK_CYCLES < 2) begin : g_bad
        $error("arsq_top: TICK_CYCLES must be at least 2");
    end

    arsq_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    assign lines = {r_reg.s2.init_line_external, r_reg.s2.init_line_three,
                    r_reg.s2.init_line_two, r_reg.s2.init_line_one};
    assign brk = r_reg.s2.breaker_open_sense;
    assign syn = r_reg.s2.sync_ok_in;
    assign cblk = r_reg.s2.close_block_in;
    assign inh = r_reg.s2.reclose_inhibit_in;
    assign idx = apb.paddr[7:2];
    assign mapped = (int'(idx) <= IDX_DEAD + NUM_SHOTS - 1)
                    || (int'(idx) >= IDX_DLY && int'(idx) < IDX_DLY + (NUM_SHOTS + 1) * NUM_LINES);

    // Shot selection from the pointer upward
    always_comb begin
        logic [NUM_LINES-1:0] st_act;
        logic [NUM_LINES-1:0] bl_act;
        logic [NUM_LINES-1:0] rdy;
        st_act = '0;
        bl_act = '0;
        rdy = '0;
        sel = PTR_NONE;
        go = 1'b0;
        hold_now = 1'b0;
        for (int s = NUM_SHOTS + 1; s >= 1; s--) begin
            for (int l = 0; l < NUM_LINES; l++) begin
                st_act[l] = lines[l] && r_reg.act[s-1][2*l +: 2] == ACT_START;
                bl_act[l] = lines[l] && r_reg.act[s-1][2*l +: 2] == ACT_BLOCK;
                rdy[l] = st_act[l] && (r_reg.lcnt[l] >= r_reg.dly[(s-1)*NUM_LINES+l]
                         || (s <= NUM_SHOTS && !r_reg.mode[s-1]));
            end
            if (s >= int'(r_reg.ptr)) begin
                if (|st_act && !(|bl_act)) begin
                    sel = 3'(s);
                    go = |rdy;
                end
                if (|rdy && |bl_act) begin
                    hold_now = 1'b1;
                end
            end
        end
    end

    // Register read mux
    always_comb begin
        rd = 32'h0000_0000;
        if (int'(idx) == IDX_CTRL) begin
            rd[4:0] = r_reg.mode;
        end else if (int'(idx) == IDX_STATUS) begin
            rd = {21'h000000, r_reg.held, brk, r_reg.shot, r_reg.st, r_reg.ptr};
        end else if (int'(idx) == IDX_TD) begin
            rd[TW-1:0] = r_reg.td;
        end else if (int'(idx) == IDX_TR) begin
            rd[TW-1:0] = r_reg.tr;
        end else if (int'(idx) >= IDX_ACT && int'(idx) <= IDX_ACT + NUM_SHOTS) begin
            rd[7:0] = r_reg.act[int'(idx) - IDX_ACT];
        end else if (int'(idx) >= IDX_DEAD && int'(idx) < IDX_DEAD + NUM_SHOTS) begin
            rd[TW-1:0] = r_reg.dead[int'(idx) - IDX_DEAD];
        end else if (mapped && int'(idx) >= IDX_DLY) begin
            rd[TW-1:0] = r_reg.dly[int'(idx) - IDX_DLY];
        end
    end

    always_comb begin
        r_next = r_reg;
        r_next.s1 = pins;
        r_next.s2 = r_reg.s1;
        // Per-line start delay counters
        for (int l = 0; l < NUM_LINES; l++) begin
            if (!lines[l]) begin
                r_next.lcnt[l] = '0;
            end else if (tick && r_reg.lcnt[l] != '1) begin
                r_next.lcnt[l] = r_reg.lcnt[l] + 1'b1;
            end
        end
        if (tick) begin
            if (r_reg.recl != '0) begin
                r_next.recl = r_reg.recl - 1'b1;
            end
            if (r_reg.disc != '0) begin
                r_next.disc = r_reg.disc - 1'b1;
            end
            if (r_reg.gap != '0) begin
                r_next.gap = r_reg.gap - 1'b1;
            end
            if (r_reg.dead_cnt != '0) begin
                r_next.dead_cnt = r_reg.dead_cnt - 1'b1;
            end
        end
        if (inh) begin
            r_next.ptr = PTR_LOCK;
            r_next.st = ST_IDLE;
            r_next.open_cmd = 1'b0;
            r_next.close_cmd = 1'b0;
            r_next.recl = r_reg.tr;
            r_next.disc = '0;
            r_next.held = 1'b0;
        end else begin
            case (r_reg.st)
                ST_IDLE: begin
                    if (r_reg.disc != '0 && |lines && r_reg.ptr < PTR_FINAL) begin
                        r_next.ptr = PTR_FINAL;
                        r_next.disc = '0;
                    end else if (sel != PTR_NONE && go) begin
                        if (r_reg.held) begin
                            r_next.st = ST_GAP;
                            r_next.gap = GAP_MS;
                            r_next.held = 1'b0;
                        end else begin
                            r_next.shot = sel;
                            r_next.ptr = sel;
                            r_next.st = ST_OPEN;
                            if (sel == PTR_FINAL) begin
                                r_next.open_cmd = 1'b1;
                            end else begin
                                r_next.open_cmd = r_reg.mode[sel-3'h1];
                            end
                        end
                    end else begin
                        r_next.held = hold_now || (r_reg.held && |lines);
                        if (brk) begin
                            r_next.ptr = PTR_LOCK;
                            r_next.recl = r_reg.tr;
                        end else if (r_reg.recl == '0 && r_reg.ptr != PTR_FIRST && !(|lines)) begin
                            r_next.ptr = PTR_FIRST;
                        end
                    end
                end
                ST_GAP: begin
                    if (r_reg.gap == '0) begin
                        r_next.st = ST_IDLE;
                    end
                end
                ST_OPEN: begin
                    if (brk) begin
                        r_next.open_cmd = 1'b0;
                        if (r_reg.shot == PTR_FINAL) begin
                            r_next.ptr = PTR_LOCK;
                            r_next.recl = r_reg.tr;
                            r_next.st = ST_IDLE;
                        end else begin
                            r_next.dead_cnt = r_reg.dead[r_reg.shot-3'h1];
                            r_next.st = ST_DEAD;
                        end
                    end
                end
                ST_DEAD: begin
                    if (!brk) begin
                        r_next.ptr = PTR_LOCK;
                        r_next.recl = r_reg.tr;
                        r_next.st = ST_IDLE;
                    end else if (r_reg.dead_cnt == '0 && syn && !cblk && !(|lines)) begin
                        r_next.close_cmd = 1'b1;
                        r_next.st = ST_CLOSE;
                        r_next.recl = r_reg.tr;
                        r_next.disc = (r_reg.shot < PTR_LAST) ? r_reg.td : '0;
                        r_next.ptr = (r_reg.shot == PTR_LAST) ? PTR_LOCK : r_reg.shot + 3'h1;
                    end
                end
                ST_CLOSE: begin
                    if (!brk) begin
                        r_next.close_cmd = 1'b0;
                        r_next.st = ST_IDLE;
                    end
                end
                default: begin
                    r_next.st = ST_IDLE;
                end
            endcase
        end
        r_next.close_cmd = r_next.close_cmd && !r_next.open_cmd;
        // APB slave
        if (apb.psel && !apb.penable) begin
            r_next.prdata = mapped ? rd : 32'h0000_0000;
        end
        if (apb.psel && apb.penable && apb.pwrite && mapped) begin
            if (int'(idx) == IDX_CTRL) begin
                r_next.mode = apb.pwdata[4:0];
            end else if (int'(idx) == IDX_TD) begin
                r_next.td = apb.pwdata[TW-1:0];
            end else if (int'(idx) == IDX_TR) begin
                r_next.tr = apb.pwdata[TW-1:0];
            end else if (int'(idx) >= IDX_ACT && int'(idx) <= IDX_ACT + NUM_SHOTS) begin
                r_next.act[int'(idx) - IDX_ACT] = apb.pwdata[7:0];
            end else if (int'(idx) >= IDX_DEAD && int'(idx) < IDX_DEAD + NUM_SHOTS) begin
                r_next.dead[int'(idx) - IDX_DEAD] = apb.pwdata[TW-1:0];
            end else if (int'(idx) >= IDX_DLY) begin
                r_next.dly[int'(idx) - IDX_DLY] = apb.pwdata[TW-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.ptr <= PTR_FIRST;
            r_reg.mode <= MODE_RST;
            r_reg.td <= TD_RST;
            r_reg.tr <= TR_RST;
            r_reg.dead <= {NUM_SHOTS{DEAD_RST}};
        end else begin
            r_reg <= r_next;
        end
    end

    assign prdata = r_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = apb.psel && apb.penable && !mapped;
    assign breaker_open_cmd = r_reg.open_cmd;
    assign breaker_close_cmd = r_reg.close_cmd;
    assign shot_pointer = r_reg.ptr;

    for (genvar g = 0; g < NUM_SHOTS; g++) begin : g_pend
        assign shot_pending[g] = r_reg.ptr == 3'(g + 1) && r_reg.st == ST_IDLE;
    end

    property p_no_both;
        @(posedge pclk) disable iff (!presetn) !(breaker_open_cmd && breaker_close_cmd);
    endproperty
    a_no_both: assert property (p_no_both) else $error("open and close together");

    property p_lock_ignore;
        @(posedge pclk) disable iff (!presetn)
            (r_reg.st == ST_IDLE && r_reg.ptr == PTR_LOCK) |=> r_reg.st == ST_IDLE && !breaker_open_cmd;
    endproperty
    a_lock_ignore: assert property (p_lock_ignore) else $error("shot started at lock-out");

    property p_not_lower;
        @(posedge pclk) disable iff (!presetn)
            (r_reg.st == ST_IDLE ##1 r_reg.st == ST_OPEN) |-> r_reg.shot >= $past(r_reg.ptr);
    endproperty
    a_not_lower: assert property (p_not_lower) else $error("shot below pointer started");

    property p_start_cause;
        @(posedge pclk) disable iff (!presetn)
            (r_reg.st == ST_IDLE ##1 r_reg.st == ST_OPEN) |-> $past(sel) == r_reg.shot && $past(go);
    endproperty
    a_start_cause: assert property (p_start_cause) else $error("shot started without start line");

    property p_disc;
        @(posedge pclk) disable iff (!presetn)
            (r_reg.st == ST_IDLE && r_reg.disc != '0 && |lines && r_reg.ptr < PTR_FINAL && !inh)
            |=> r_reg.ptr == PTR_FINAL;
    endproperty
    a_disc: assert property (p_disc) else $error("discrimination did not set pointer 6");

    property p_close_cond;
        @(posedge pclk) disable iff (!presetn) $rose(breaker_close_cmd) |-> $past(syn) && !$past(cblk);
    endproperty
    a_close_cond: assert property (p_close_cond) else $error("close without sync or under block");

    property p_dead_close;
        @(posedge pclk) disable iff (!presetn)
            (r_reg.st == ST_DEAD && r_reg.dead_cnt == '0 && brk && syn && !cblk && !(|lines) && !inh)
            |=> breaker_close_cmd ##0 r_reg.recl == r_reg.tr;
    endproperty
    a_dead_close: assert property (p_dead_close) else $error("no close at dead time expiry");

    property p_reclaim_reset;
        @(posedge pclk) disable iff (!presetn)
            (r_reg.st == ST_IDLE && r_reg.recl == '0 && r_reg.ptr == PTR_LOCK && !brk && !inh && !(|lines))
            |=> r_reg.ptr == PTR_FIRST;
    endproperty
    a_reclaim_reset: assert property (p_reclaim_reset) else $error("pointer not reset after reclaim");

    property p_gap_load;
        @(posedge pclk) disable iff (!presetn)
            (r_reg.st == ST_IDLE ##1 r_reg.st == ST_GAP) |-> r_reg.gap == GAP_MS && !r_reg.held;
    endproperty
    a_gap_load: assert property (p_gap_load) else $error("release gap not loaded");

    property p_open_release;
        @(posedge pclk) disable iff (!presetn) (r_reg.st == ST_OPEN && brk && !inh) |=> !breaker_open_cmd;
    endproperty
    a_open_release: assert property (p_open_release) else $error("open held after breaker opened");

    c_shot: cover property (@(posedge pclk) disable iff (!presetn) $rose(breaker_open_cmd));
    c_close: cover property (@(posedge pclk) disable iff (!presetn) $rose(breaker_close_cmd));
    c_gap: cover property (@(posedge pclk) disable iff (!presetn) r_reg.st == ST_GAP);
    c_final: cover property (@(posedge pclk) disable iff (!presetn) r_reg.ptr == PTR_FINAL);
endmodule
`default_nettype wire

// File: dv/arsq_breaker.sv
// Breaker with position feedback, far side of the sequencer.
// Assumes level commands held until the position changes.
`timescale 1ns/1ps
`default_nettype none
module arsq_breaker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic open_cmd,
    input wire logic close_cmd,
    input wire logic trip,
    input wire logic [7:0] delay,
    output logic breaker_open
);
    logic [7:0] cnt;
    logic want;
    // Open wins over close
    assign want = open_cmd ? 1'b1 : (close_cmd ? 1'b0 : breaker_open);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            breaker_open <= 1'b0;
            cnt <= 8'h00;
        end else if (trip) begin
            breaker_open <= 1'b1;
        end else if (want != breaker_open) begin
            if (cnt >= delay) begin
                breaker_open <= want;
                cnt <= 8'h00;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end else begin
            cnt <= 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench of the auto-reclose sequencer.
// Assumes a 1 ms tick of 10 pclk cycles and a breaker model.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import arsq_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    arsq_apb_s apb = '0;
    arsq_pins_s drv = '0;
    arsq_pins_s pins;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready;
    logic pslverr;
    logic err;
    logic open_cmd;
    logic close_cmd;
    logic brk;
    logic trip = 1'b0;
    logic overlap = 1'b0;
    logic [7:0] bdly = 8'h03;
    logic [2:0] ptr;
    logic [4:0] pend;
    int fails = 0;
    int checked = 0;
    int cyc = 0;
    int waited;

    always #50 pclk = ~pclk;
    always_comb begin
        pins = drv;
        pins.breaker_open_sense = brk;
    end

    arsq_top #(.TICK_CYCLES(10)) u_arsq_top (.pclk(pclk), .presetn(presetn), .apb(apb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins), .breaker_open_cmd(open_cmd),
        .breaker_close_cmd(close_cmd), .shot_pointer(ptr), .shot_pending(pend));
    arsq_breaker u_arsq_breaker (.pclk(pclk), .presetn(presetn), .open_cmd(open_cmd), .close_cmd(close_cmd),
        .trip(trip), .delay(bdly), .breaker_open(brk));

    task automatic stop_test;
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (open_cmd === 1'b1 && close_cmd === 1'b1) overlap <= 1'b1;
        if (cyc == 20000) begin
            fails++;
            stop_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        apb.psel <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite <= w;
        apb.paddr <= a;
        apb.pwdata <= d;
        @(posedge pclk);
        apb.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        apb.psel <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    function automatic logic [2:0] sel_val(input int w);
        case (w)
            0: return ptr;
            1: return {2'h0, open_cmd};
            default: return {2'h0, close_cmd};
        endcase
    endfunction

    // Wait at falling edges for settled outputs
    task automatic wait_for(input int w, input logic [2:0] v);
        waited = 0;
        while (sel_val(w) !== v && waited < 3000) begin
            @(negedge pclk);
            waited++;
        end
        check(32'(sel_val(w)), 32'(v));
    endtask

    initial begin
        drv.sync_ok_in = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        check(32'(pend), 32'h1);
        xfer(1'b0, OFF_CTRL, 32'h0);
        check(rd, 32'h0);
        xfer(1'b0, OFF_TR, 32'h0);
        check(rd, 32'(TR_RST));
        xfer(1'b0, OFF_DEAD, 32'h0);
        check(rd, 32'(DEAD_RST));
        xfer(1'b0, OFF_STATUS, 32'h0);
        check(rd & 32'h7, 32'(PTR_FIRST));
        xfer(1'b0, 8'hFC, 32'h0);
        check(32'(err), 32'h1);
        xfer(1'b1, OFF_TR, 32'h14);
        xfer(1'b1, OFF_DEAD, 32'h5);
        xfer(1'b1, OFF_DEAD + 8'h04, 32'h5);
        xfer(1'b1, OFF_CTRL, 32'h1F);
        xfer(1'b1, OFF_ACT, 32'h1);
        xfer(1'b1, OFF_DLY, 32'h3);
        xfer(1'b0, OFF_DLY, 32'h0);
        check(rd, 32'h3);
        @(posedge pclk);
        drv.init_line_one <= 1'b1;
        repeat (20) @(posedge pclk);
        drv.init_line_one <= 1'b0;
        repeat (40) @(negedge pclk);
        check(32'(open_cmd), 32'h0);
        @(posedge pclk);
        drv.init_line_one <= 1'b1;
        wait_for(1, 3'h1);
        check(32'(waited >= 20), 32'h1);
        @(posedge pclk);
        drv.init_line_one <= 1'b0;
        drv.close_block_in <= 1'b1;
        drv.sync_ok_in <= 1'b0;
        repeat (150) @(negedge pclk);
        check(32'(close_cmd), 32'h0);
        @(posedge pclk);
        drv.close_block_in <= 1'b0;
        repeat (20) @(negedge pclk);
        check(32'(close_cmd), 32'h0);
        @(posedge pclk);
        drv.sync_ok_in <= 1'b1;
        wait_for(2, 3'h1);
        wait_for(0, 3'h2);
        wait_for(0, PTR_FIRST);
        // Delay runs out under a block
        xfer(1'b1, OFF_ACT, 32'h9);
        @(posedge pclk);
        drv.init_line_one <= 1'b1;
        drv.init_line_two <= 1'b1;
        repeat (100) @(negedge pclk);
        check(32'(open_cmd), 32'h0);
        check(32'(ptr), 32'(PTR_FIRST));
        @(posedge pclk);
        drv.init_line_two <= 1'b0;
        wait_for(1, 3'h1);
        check(32'(waited >= 480 && waited <= 540), 32'h1);
        @(posedge pclk);
        drv.init_line_one <= 1'b0;
        wait_for(0, 3'h2);
        wait_for(0, PTR_FIRST);
        // Blocked shot falls through, slow breaker
        bdly <= 8'h40;
        xfer(1'b1, OFF_ACT + 8'h04, 32'h1);
        @(posedge pclk);
        drv.init_line_one <= 1'b1;
        drv.init_line_two <= 1'b1;
        wait_for(1, 3'h1);
        @(posedge pclk);
        drv.init_line_one <= 1'b0;
        drv.init_line_two <= 1'b0;
        wait_for(0, 3'h3);
        wait_for(0, PTR_FIRST);
        // Trip-initiated shot, then discrimination
        bdly <= 8'h03;
        xfer(1'b1, OFF_CTRL, 32'h1E);
        xfer(1'b1, OFF_TD, 32'hA);
        xfer(1'b1, OFF_ACT, 32'h1);
        xfer(1'b1, OFF_DLY, 32'h0);
        @(posedge pclk);
        drv.init_line_one <= 1'b1;
        repeat (5) @(negedge pclk);
        check(32'(open_cmd), 32'h0);
        check(32'(pend), 32'h0);
        @(posedge pclk);
        trip <= 1'b1;
        @(posedge pclk);
        trip <= 1'b0;
        repeat (30) @(negedge pclk);
        check(32'(open_cmd), 32'h0);
        @(posedge pclk);
        drv.init_line_one <= 1'b0;
        wait_for(2, 3'h1);
        @(posedge pclk);
        drv.init_line_one <= 1'b1;
        wait_for(0, PTR_FINAL);
        @(posedge pclk);
        drv.init_line_one <= 1'b0;
        wait_for(0, PTR_FIRST);
        @(posedge pclk);
        drv.reclose_inhibit_in <= 1'b1;
        wait_for(0, PTR_LOCK);
        @(posedge pclk);
        drv.reclose_inhibit_in <= 1'b0;
        drv.init_line_one <= 1'b1;
        repeat (100) @(negedge pclk);
        check(32'(open_cmd), 32'h0);
        check(32'(ptr), 32'(PTR_LOCK));
        @(posedge pclk);
        drv.init_line_one <= 1'b0;
        wait_for(0, PTR_FIRST);
        check(32'(overlap), 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
